// File: serial_rx_map.svh
// Address map, field positions and reset values of the serial receive path
`ifndef SERIAL_RX_MAP_SVH
`define SERIAL_RX_MAP_SVH

`define RX_PORT_CH0_ADDR   8'h08
`define RX_PORT_CH1_ADDR   8'h09
`define RX_FIFO_DEPTH      4
`define RX_FIFO_AW         2
`define STAT_RX_DATA_FULL_FLAG_BIT      7
`define STAT_RX_OVERRUN_FLAG_BIT      6
`define STAT_PE_BIT        5
`define STAT_FE_BIT        4
`define RX_DATA_RESET      8'h00
`define OVS_DEFAULT        16'h0010

`endif

// File: serial_rx_pkg.sv
// Types shared by the serial receive path
package serial_rx_pkg;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

  // Status carried with each character: parity, framing, overrun, break
  typedef struct packed {
    logic parityErr;
    logic framingErr;
    logic overrun;
    logic brk;
  } rx_status_s;

endpackage : serial_rx_pkg

// File: rx_fifo_mem.sv
// Small memory for the receive data and status FIFOs, registered read
`timescale 1ns/100ps
`include "serial_rx_map.svh"

module rx_fifo_mem #(
  parameter int WIDTH = 12
) (
  // Clock
  input  wire logic                   sys_clk,
  // Write side
  input  wire logic                   wrEn,
  input  wire logic [`RX_FIFO_AW-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]       wrData,
  // Read side
  input  wire logic [`RX_FIFO_AW-1:0] rdAddr,
  output logic      [WIDTH-1:0]       rdData
);

  logic [WIDTH-1:0] mem [`RX_FIFO_DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Read data registered; a write to the head lands one cycle later
  always_ff @(posedge sys_clk) begin
    rdData <= mem[rdAddr];
  end

endmodule : rx_fifo_mem

// File: serial_rx_shift.sv
// Receive shift register: assembles one character from the serial input
`timescale 1ns/100ps
`include "serial_rx_map.svh"

module serial_rx_shift
  import serial_rx_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Control
  input  wire logic        enable,
  input  wire logic [15:0] ovsDiv,
  input  wire logic        parityEn,
  input  wire logic        parityOdd,
  // Serial input, already synchronised
  input  wire logic        rxIn,
  // Completed character
  output logic             charDone,
  output logic [7:0]       charData,
  output rx_status_s       charStat
);

  rx_state_e   state_reg;
  logic [15:0] divCnt_reg;
  logic [3:0]  phase_reg;
  logic [3:0]  bitCnt_reg;
  logic [7:0]  shift_reg;
  logic        par_reg;
  logic        tick;

  // Oversample tick from a divider, sixteen per bit
  assign tick = (divCnt_reg == 16'h0000);

  always_ff @(posedge sys_clk) begin
    if (!nrst || !enable || tick) begin
      divCnt_reg <= ovsDiv - 16'h0001;
    end else begin
      divCnt_reg <= divCnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    charDone <= 1'b0;
    if (!nrst || !enable) begin
      state_reg  <= RX_IDLE;
      phase_reg  <= 4'h0;
      bitCnt_reg <= 4'h0;
      shift_reg  <= 8'h00;
      par_reg    <= 1'b0;
      charData   <= `RX_DATA_RESET;
      charStat   <= '0;
    end else if (tick) begin
      phase_reg <= phase_reg + 4'h1;
      case (state_reg)
        RX_IDLE: begin
          phase_reg <= 4'h0;
          if (!rxIn) begin
            state_reg <= RX_START;
          end
        end
        RX_START: begin
          // Mid-bit check rejects glitches shorter than half a bit
          if (phase_reg == 4'h7) begin
            phase_reg <= 4'h0;
            state_reg <= rxIn ? RX_IDLE : RX_DATA;
            bitCnt_reg <= 4'h0;
            par_reg    <= parityOdd;
          end
        end
        RX_DATA: begin
          if (phase_reg == 4'hF) begin
            shift_reg  <= {rxIn, shift_reg[7:1]};
            par_reg    <= par_reg ^ rxIn;
            bitCnt_reg <= bitCnt_reg + 4'h1;
            // Eight bits either way: eight data, or seven data then parity
            if (bitCnt_reg == 4'h7) begin
              state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (phase_reg == 4'hF) begin
            state_reg <= RX_IDLE;
            charDone  <= 1'b1;
            // Parity bit arrives last and lands in the top bit
            charData  <= parityEn ? {1'b0, shift_reg[6:0]} : shift_reg;
            // Stop bit low means framing error
            charStat.framingErr <= ~rxIn;
            charStat.parityErr  <= parityEn & par_reg;
            charStat.brk        <= ~rxIn & (shift_reg == 8'h00);
            charStat.overrun    <= 1'b0;
          end
        end
        default: state_reg <= RX_IDLE;
      endcase
    end
  end

endmodule : serial_rx_shift

// File: serial_rx_path.sv
// Receive path of one serial channel: shift register, data and status FIFOs
// How it works
// - Transmit data register reads back its value and never disturbs transmission.
// - Bits from the serial receive pin are shifted into an internal shift register.
// - A complete character moves into the FIFO automatically when there is room.
// - Overrun is flagged when another character completes while one is still held.
// - The shift register has no software access.
// - The receive port is read-only at 08H for channel 0 and 09H for channel 1.
// - The receive data FIFO holds four characters.
// - A port read returns the oldest buffered character.
// - Reception continues while the FIFO is full, holding one extra character.
// - A four-entry status FIFO holds parity, framing, overrun and break per character.
// - Status bits show the entry of the oldest character.
// - Data-full bit 7 sets on entry and clears on emptying, halt mode or reset.
// - Overrun shows when the last good character is oldest and clears by error reset.
// - After overrun nothing more is loaded until the flag is set and cleared.
// - Framing error shows when its character is oldest and clears by error reset.
`timescale 1ns/100ps
`include "serial_rx_map.svh"

module serial_rx_path
  import serial_rx_pkg::*;
#(
  parameter logic [7:0] PORT_ADDR = `RX_PORT_CH0_ADDR
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // I/O access port
  input  wire logic [7:0]  ioAddr,
  input  wire logic        ioRd,
  input  wire logic        ioWr,
  output logic [7:0]       ioRdData,
  output logic             ioRdHit,
  // Transmit data register shadow
  input  wire logic        txWr,
  input  wire logic [7:0]  txWrData,
  output logic [7:0]       txData,
  // Control
  input  wire logic        rxEnable,
  input  wire logic        ioHaltMode,
  input  wire logic        errorFlagReset,
  input  wire logic        parityEn,
  input  wire logic        parityOdd,
  input  wire logic [15:0] ovsDiv,
  // Serial pin
  input  wire logic        serialRxInput,
  // Status of oldest character
  output logic [7:0]       statusBits
);

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  logic rxMeta_reg;
  logic rxS1_reg;
  logic rxS2_reg;
  logic rxClean_reg;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rxMeta_reg  <= 1'b1;
      rxS1_reg    <= 1'b1;
      rxS2_reg    <= 1'b1;
      rxClean_reg <= 1'b1;
    end else begin
      rxMeta_reg <= serialRxInput;
      rxS1_reg   <= rxMeta_reg;
      rxS2_reg   <= rxS1_reg;
      if (rxS1_reg == rxS2_reg) begin
        rxClean_reg <= rxS2_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  function automatic logic addrHit(input logic [7:0] a);
    addrHit = (a == PORT_ADDR);
  endfunction : addrHit

  logic runOk;
  logic rdPort;
  assign runOk = rxEnable & ~ioHaltMode;
  // A write to the receive port has no effect: the port is read-only
  // Port decodes for reads only
  assign rdPort  = ioRd & addrHit(ioAddr);
  assign ioRdHit = rdPort;

  // ------------------------------------------------------------
  // Transmit data register
  // ------------------------------------------------------------
  // Read back has no side effect, so a transfer in flight is never disturbed
  // Software write, free read back
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      txData <= 8'h00;
    end else if (txWr) begin
      txData <= txWrData;
    end
  end

  // ------------------------------------------------------------
  // Shift register
  // ------------------------------------------------------------
  logic       charDone;
  logic [7:0] charData;
  rx_status_s charStat;

  // Shift register is internal, no software path
  serial_rx_shift u_shift (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .enable    (runOk),
    .ovsDiv    (ovsDiv),
    .parityEn  (parityEn),
    .parityOdd (parityOdd),
    .rxIn      (rxClean_reg),
    .charDone  (charDone),
    .charData  (charData),
    .charStat  (charStat)
  );

  // ------------------------------------------------------------
  // FIFO control
  // ------------------------------------------------------------
  logic [`RX_FIFO_AW:0]   count_reg;
  logic [`RX_FIFO_AW-1:0] wrPtr_reg;
  logic [`RX_FIFO_AW-1:0] rdPtr_reg;
  logic                   held_reg;
  logic [7:0]             heldData_reg;
  rx_status_s             heldStat_reg;
  logic                   ovrPending_reg;
  logic                   ovrFlag_reg;
  logic                   peFlag_reg;
  logic                   feFlag_reg;
  logic [7:0]             lastData_reg;
  logic                   full;
  logic                   empty;
  logic                   push;
  logic                   pop;
  logic                   blocked;
  logic [11:0]            wrWord;
  logic [11:0]            headWord;
  logic [`RX_FIFO_AW-1:0] headAddr;

  assign full    = (count_reg == (`RX_FIFO_AW+1)'(`RX_FIFO_DEPTH));
  assign empty   = (count_reg == '0);
  // Loading stops while an overrun is unresolved
  assign blocked = ovrPending_reg | ovrFlag_reg;
  // Automatic transfer when FIFO has room
  assign push    = held_reg & (~full | pop) & ~blocked;
  assign pop     = rdPort & ~empty;
  assign wrWord  = {heldStat_reg, heldData_reg};
  assign headAddr = pop ? rdPtr_reg + 2'd1 : rdPtr_reg;

  // Four-entry storage for data and status
  rx_fifo_mem #(.WIDTH(12)) u_mem (
    .sys_clk (sys_clk),
    .wrEn    (push),
    .wrAddr  (wrPtr_reg),
    .wrData  (wrWord),
    .rdAddr  (headAddr),
    .rdData  (headWord)
  );

  // Pointers and count; push and pop may land together
  always_ff @(posedge sys_clk) begin
    if (!nrst || ioHaltMode) begin
      count_reg <= '0;
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 2'd1;
      end
      // Data and status pop as one
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 2'd1;
      end
      count_reg <= count_reg + (`RX_FIFO_AW+1)'(push) - (`RX_FIFO_AW+1)'(pop);
    end
  end

  // One character held in the shift stage while the FIFO is full
  always_ff @(posedge sys_clk) begin
    if (!nrst || ioHaltMode) begin
      held_reg     <= 1'b0;
      heldData_reg <= `RX_DATA_RESET;
      heldStat_reg <= '0;
    end else if (charDone && !blocked && (!held_reg || push)) begin
      // Next character accepted while FIFO full
      held_reg     <= 1'b1;
      heldData_reg <= charData;
      heldStat_reg <= charStat;
    end else if (push) begin
      held_reg <= 1'b0;
    end else if (charDone && !blocked) begin
      // Overrun drops the held character as well
      held_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Overrun tracking
  // ------------------------------------------------------------
  // Pending until the last good character reaches the head; the distance is
  // counted in pops so the flag never shows ahead of its character
  logic [`RX_FIFO_AW:0] ovrDist_reg;

  always_ff @(posedge sys_clk) begin
    if (!nrst || ioHaltMode) begin
      ovrPending_reg <= 1'b0;
      ovrDist_reg    <= '0;
      ovrFlag_reg    <= 1'b0;
    end else begin
      // Character done while one still held
      if (charDone && held_reg && !push && !blocked) begin
        ovrPending_reg <= 1'b1;
        ovrDist_reg    <= count_reg - (`RX_FIFO_AW+1)'(1);
      end else if (ovrPending_reg && pop) begin
        if (ovrDist_reg <= (`RX_FIFO_AW+1)'(1)) begin
          // Flag shows once last good char is oldest
          ovrPending_reg <= 1'b0;
          ovrFlag_reg    <= 1'b1;
        end else begin
          ovrDist_reg <= ovrDist_reg - (`RX_FIFO_AW+1)'(1);
        end
      end else if (ovrPending_reg && ovrDist_reg == '0) begin
        ovrPending_reg <= 1'b0;
        ovrFlag_reg    <= 1'b1;
      end else if (errorFlagReset) begin
        ovrFlag_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Head status and read data
  // ------------------------------------------------------------
  logic       headValid_reg;
  rx_status_s headStat;

  // Status field of the entry currently at the head
  assign headStat = headWord[11:8];

  always_ff @(posedge sys_clk) begin
    if (!nrst || ioHaltMode) begin
      headValid_reg <= 1'b0;
    end else begin
      headValid_reg <= ~empty & ~pop | (count_reg > (`RX_FIFO_AW+1)'(1));
    end
  end

  // Sticky error flags latched from the head entry; set beats clear
  always_ff @(posedge sys_clk) begin
    if (!nrst || ioHaltMode) begin
      peFlag_reg <= 1'b0;
      feFlag_reg <= 1'b0;
    end else begin
      // Framing error appears when its char is oldest
      if (headValid_reg && headStat.framingErr) begin
        feFlag_reg <= 1'b1;
      end else if (errorFlagReset) begin
        feFlag_reg <= 1'b0;
      end
      if (headValid_reg && headStat.parityErr) begin
        peFlag_reg <= 1'b1;
      end else if (errorFlagReset) begin
        peFlag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      lastData_reg <= `RX_DATA_RESET;
    end else if (pop) begin
      lastData_reg <= headWord[7:0];
    end
  end
  assign ioRdData = headValid_reg ? headWord[7:0] : lastData_reg;

  // ------------------------------------------------------------
  // Status register
  // ------------------------------------------------------------
  // Break is kept per character but has no bit of its own here
  // Status reflects the oldest entry
  always_comb begin
    statusBits = 8'h00;
    statusBits[`STAT_RX_DATA_FULL_FLAG_BIT] = headValid_reg;
    statusBits[`STAT_RX_OVERRUN_FLAG_BIT] = ovrFlag_reg;
    statusBits[`STAT_PE_BIT]   = peFlag_reg;
    statusBits[`STAT_FE_BIT]   = feFlag_reg;
  end

endmodule : serial_rx_path

// File: serial_rx_path_asserts.sv
// Port checker for the serial receive path
`timescale 1ns/100ps

module serial_rx_path_asserts #(
  parameter logic [7:0] PORT_ADDR = 8'h08
) (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [7:0]  ioAddr,
  input wire logic        ioRd,
  input wire logic        ioRdHit,
  input wire logic [7:0]  ioRdData,
  input wire logic        txWr,
  input wire logic [7:0]  txWrData,
  input wire logic [7:0]  txData,
  input wire logic        ioHaltMode,
  input wire logic        errorFlagReset,
  input wire logic [7:0]  statusBits
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  rdhit_decode_a: assert property (ioRdHit == (ioRd && ioAddr == PORT_ADDR))
    else $error("port decode wrong");
  unused_bits_a: assert property (statusBits[3:0] == 4'h0)
    else $error("unused status bits set");
  // Sync reset must clear status bits, read data and the tx register on the next edge
  reset_zero_a: assert property (disable iff (1'b0) !nrst |=> (statusBits == 8'h00)
    && (ioRdData == 8'h00) && (txData == 8'h00)) else $error("outputs not cleared by reset");
  halt_clears_a: assert property (ioHaltMode |=> statusBits[7:4] == 4'h0)
    else $error("halt mode left flags set");
  tx_load_a: assert property (txWr |=> txData == $past(txWrData))
    else $error("tx register not loaded");
  tx_hold_a: assert property (!txWr && !ioHaltMode |=> $stable(txData))
    else $error("tx register disturbed");
  full_fall_a: assert property ($fell(statusBits[7]) |->
    $past(ioRdHit) || $past(ioRdHit, 2) || $past(ioHaltMode)) else $error("full flag lost");
  rx_overrun_flag_fall_a: assert property ($fell(statusBits[6]) |->
    $past(errorFlagReset) || $past(ioHaltMode)) else $error("overrun flag lost");
  rx_overrun_flag_head_a: assert property ($rose(statusBits[6]) |-> statusBits[7])
    else $error("overrun shown with empty buffer");
  fe_fall_a: assert property ($fell(statusBits[4]) |->
    $past(errorFlagReset) || $past(ioHaltMode)) else $error("framing flag lost");

  cover property ($rose(statusBits[7]));
  cover property ($rose(statusBits[6]));
  cover property ($rose(statusBits[4]));
  cover property (ioRdHit && statusBits[7]);
endmodule : serial_rx_path_asserts

bind serial_rx_path serial_rx_path_asserts #(.PORT_ADDR(PORT_ADDR)) chk (
  .sys_clk(sys_clk), .nrst(nrst), .ioAddr(ioAddr), .ioRd(ioRd), .ioRdHit(ioRdHit),
  .ioRdData(ioRdData), .txWr(txWr), .txWrData(txWrData), .txData(txData),
  .ioHaltMode(ioHaltMode), .errorFlagReset(errorFlagReset), .statusBits(statusBits));

// File: serial_tx_model.sv
// Remote asynchronous transmitter driving the receive pin
`timescale 1ns/100ps

module serial_tx_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic sys_clk,
  output logic     txLine
);
  // Line idles high between frames
  initial txLine = 1'b1;

  task automatic send_char(input logic [7:0] d, input logic stopBit);
    logic [9:0] frame;
    frame = {stopBit, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      #2 txLine = frame[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    #2 txLine = 1'b1;
  endtask : send_char
endmodule : serial_tx_model

// File: test_serial_rx_path.sv
// Self-checking bench for the serial receive path
`timescale 1ns/100ps

module test_serial_rx_path;
  typedef struct packed {
    logic [7:0] d;
    logic       stopBit;
    logic [1:0] par;
    logic [7:0] expD;
    logic [7:0] expStat;
  } row_s;

  logic       sys_clk = 1'b0, nrst = 1'b0, ioRd = 1'b0, ioWr = 1'b0, txWr = 1'b0;
  logic       ioHaltMode = 1'b0, errorFlagReset = 1'b0, ioRdHit;
  logic       rxEnable = 1'b1, parityEn = 1'b0, parityOdd = 1'b0;
  logic [7:0] ioAddr = 8'h08, txWrData = 8'h00, ioRdData, txData, statusBits, v;
  wire        serialRx;
  int         n_mismatch = 0, num_checks = 0;
  row_s       rows[8] = '{
    '{8'h55, 1'b1, 2'b00, 8'h55, 8'h80}, '{8'hA3, 1'b1, 2'b00, 8'hA3, 8'h80},
    '{8'h00, 1'b1, 2'b00, 8'h00, 8'h80}, '{8'hFF, 1'b1, 2'b00, 8'hFF, 8'h80},
    '{8'hC3, 1'b0, 2'b00, 8'hC3, 8'h90}, '{8'h35, 1'b1, 2'b10, 8'h35, 8'h80},
    '{8'hB5, 1'b1, 2'b10, 8'h35, 8'hA0}, '{8'hB5, 1'b1, 2'b11, 8'h35, 8'h80}
  };

  always #12.5 sys_clk = ~sys_clk;

  serial_rx_path #(.PORT_ADDR(8'h08)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr),
    .ioRdData(ioRdData), .ioRdHit(ioRdHit), .txWr(txWr), .txWrData(txWrData),
    .txData(txData), .rxEnable(rxEnable), .ioHaltMode(ioHaltMode),
    .errorFlagReset(errorFlagReset), .parityEn(parityEn), .parityOdd(parityOdd),
    .ovsDiv(16'h0001), .serialRxInput(serialRx), .statusBits(statusBits));

  // One bit is 16 samples of a divider of one
  serial_tx_model #(.BIT_CYC(16)) remote (.sys_clk(sys_clk), .txLine(serialRx));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : cyc

  // Read data is combinational, so it is taken inside the strobe cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    ioAddr = a;
    ioRd = 1'b1;
    #1 d = ioRdData;
    cyc(1);
    ioRd = 1'b0;
    cyc(1);
  endtask : rd

  task automatic rx(input logic [7:0] d, input logic stopBit);
    remote.send_char(d, stopBit);
    cyc(8);
  endtask : rx

  task automatic error_flag_reset();
    errorFlagReset = 1'b1;
    cyc(1);
    errorFlagReset = 1'b0;
    cyc(1);
  endtask : error_flag_reset

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Whole run needs well under 10000 cycles
  initial begin
    #(20000 * 25);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    #2 nrst = 1'b1;
    cyc(4);
    foreach (rows[i]) begin
      {parityEn, parityOdd} = rows[i].par;
      rx(rows[i].d, rows[i].stopBit);
      check("status", statusBits, rows[i].expStat);
      rd(8'h08, v);
      check("data", v, rows[i].expD);
      check("full", statusBits & 8'h80, 8'h00);
      error_flag_reset();
      check("flags", statusBits, 8'h00);
    end
    parityEn = 1'b0;
    parityOdd = 1'b0;
    $display("test table done");
    for (int i = 0; i < 5; i++) remote.send_char(8'h10 + i[7:0], 1'b1);
    cyc(8);
    for (int i = 0; i < 5; i++) begin
      rd(8'h08, v);
      check("fifo", v, 8'h10 + i[7:0]);
      check("no rx_overrun_flag", statusBits & 8'h40, 8'h00);
    end
    rd(8'h08, v);
    check("empty", v, 8'h14);
    check("empty stat", statusBits, 8'h00);
    $display("test depth done");
    for (int i = 0; i < 6; i++) remote.send_char(8'h20 + i[7:0], 1'b1);
    cyc(8);
    check("pre rx_overrun_flag", statusBits, 8'h80);
    for (int i = 0; i < 3; i++) begin
      rd(8'h08, v);
      check("ovr data", v, 8'h20 + i[7:0]);
    end
    check("rx_overrun_flag", statusBits & 8'hC0, 8'hC0);
    rd(8'h08, v);
    check("last good", v, 8'h23);
    check("dropped", statusBits, 8'h40);
    error_flag_reset();
    check("rx_overrun_flag clr", statusBits & 8'h40, 8'h00);
    cyc(3);
    check("held drop", statusBits, 8'h00);
    ioHaltMode = 1'b1;
    cyc(2);
    ioHaltMode = 1'b0;
    check("halt", statusBits, 8'h00);
    $display("test overrun done");
    txWrData = 8'h5A;
    txWr = 1'b1;
    cyc(1);
    txWr = 1'b0;
    rx(8'h9A, 1'b1);
    rd(8'h09, v);
    ioWr = 1'b1;
    cyc(1);
    ioWr = 1'b0;
    check("other addr", statusBits, 8'h80);
    rd(8'h08, v);
    check("after write", v, 8'h9A);
    check("tx", txData, 8'h5A);
    rxEnable = 1'b0;
    rx(8'h77, 1'b1);
    rxEnable = 1'b1;
    check("rx off", statusBits, 8'h00);
    $display("test port done");
    rx(8'h66, 1'b1);
    nrst = 1'b0;
    cyc(3);
    check("rst stat", statusBits, 8'h00);
    check("rst data", ioRdData, 8'h00);
    nrst = 1'b1;
    cyc(2);
    $display("test reset done");
    give_verdict();
  end
endmodule : test_serial_rx_path
